// ---- design/adcs_defines.vh ----
`ifndef ADCS_DEFINES_VH
`define ADCS_DEFINES_VH

// Register indices; byte address is four times the index
`define ADCS_IDX_CTRLA      5'h00
`define ADCS_IDX_CTLC       5'h02
`define ADCS_IDX_CTLD       5'h03
`define ADCS_IDX_SAMPSET    5'h05
`define ADCS_IDX_CHSEL      5'h06
`define ADCS_IDX_COMMAND    5'h08
`define ADCS_IDX_FLAGS      5'h0B
`define ADCS_IDX_OUT        5'h10

// Field positions
`define ADCS_CTRLA_ENABLE   0
`define ADCS_CTRLA_FREERUN  1
`define ADCS_CTLC_CAP       6
`define ADCS_CTLC_REF_HI    5
`define ADCS_CTLC_REF_LO    4
`define ADCS_CTLD_INIT_HI   7
`define ADCS_CTLD_INIT_LO   5
`define ADCS_CTLD_DLY_HI    3
`define ADCS_CTLD_DLY_LO    0
`define ADCS_CMD_START      0
`define ADCS_FLAG_RDY       0

// Reset values
`define ADCS_RST_REF        2'h0
`define ADCS_RST_CHAN       5'h00
`define ADCS_RST_DLY        4'h0
`define ADCS_RST_LEN        5'h00
`define ADCS_RST_INIT       3'h0

// Reference codes
`define ADCS_REF_INTERNAL   2'h0
`define ADCS_REF_SUPPLY     2'h1
`define ADCS_REF_EXTPIN     2'h2

// Channel code that also powers the temperature sensor
`define ADCS_CHAN_TEMP      5'h1E

// Timing counts in converter-clock cycles; output and SAR codes
`define ADCS_SAMP_BASE      7'h02
`define ADCS_CONV_BASE      7'h0D
`define ADCS_INIT_SHIFT     4
`define ADCS_OUT_MAX        10'h3FF
`define ADCS_SAR_TOP        10'h200

// Peripheral clocks per converter clock
`define ADCS_PRESC_DIV      4'h4

`endif

// ---- design/adcs_presc.v ----
`timescale 1ns/1ps
// Converter clock tick; held in reset while idle so start delay is fixed
module adcs_presc (
  // System
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       run,
  // Tick
  output reg        tick_r
);
`include "adcs_defines.vh"

  reg  [3:0] cnt_r;
  wire [3:0] cnt_nxt;

  assign cnt_nxt = (cnt_r == `ADCS_PRESC_DIV - 4'h1) ? 4'h0 : cnt_r + 4'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= (cnt_r == `ADCS_PRESC_DIV - 4'h1);
    end
  end

endmodule

// ---- design/adcs_top.v ----
// Operation
// - Sampling lasts two converter cycles plus delay field plus length field.
// - Free-running restarts right after each completion; period 13 plus delay plus length.
// - Channel and reference writes land in software-visible buffer; converter uses active copy.
// - While idle, buffered selections are copied to the active copy every cycle.
// - Active copy frozen during conversion; copying resumes in the final cycle.
// - Conversion begins on first converter-clock edge after start bit is set.
// - Free-running channel change mid-conversion takes effect two conversions after the current one.
// - Input above reference clips to all-ones output code.
// - Reference field picks supply, external reference pin, or internal reference.
// - Result register holds 1023 times input over reference once ready.
// - Reference code zero selects internal reference, needed for temperature sensing.
// - Temperature-sensor channel code also switches the temperature sensor on.
// - Normal conversion takes 13 converter cycles; sample-and-hold two cycles in.
// - Single mode clears start bit at completion; set throughout conversion.
// - Ready flag clears on result read or on writing one to it.
`timescale 1ns/1ps
module adcs_top (
  // System
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [6:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_r,
  output reg         pready_r,
  output reg         pslverr_r,
  // Analog front end
  input  wire        cmp_above,
  output reg         sample_r,
  output reg  [9:0]  trial_code_r,
  output reg  [4:0]  chan_out_r,
  output reg  [1:0]  ref_out_r,
  output reg         ref_internal_r,
  output reg         temp_sensor_en_r,
  output reg         samp_cap_r,
  // Result ready event
  output reg         ready_pulse_r
);
`include "adcs_defines.vh"

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_INIT = 5'b00010;
  localparam [4:0] ST_SAMP = 5'b00100;
  localparam [4:0] ST_SAR  = 5'b01000;
  localparam [4:0] ST_LAST = 5'b10000;

  // Software-visible fields
  reg        enable_r;
  reg        freerun_r;
  reg        capsel_r;
  reg  [1:0] ref_buf_r;
  reg  [2:0] init_r;
  reg  [3:0] dly_r;
  reg  [4:0] len_r;
  reg  [4:0] chan_buf_r;
  reg        start_r;
  reg        rdy_flag_r;
  reg  [9:0] res_r;

  // Converter state
  reg  [4:0] state_r;
  reg  [6:0] cnt_r;
  reg  [9:0] bit_r;
  reg  [4:0] chan_act_r;
  reg  [1:0] ref_act_r;
  reg        first_r;
  reg        cmp_m_r;
  reg        cmp_s_r;

  wire       tick;
  wire       busy;
  wire       copy_en;
  wire       done_tick;
  wire [6:0] samp_cycles;
  wire [6:0] init_cycles;
  wire [9:0] decided;

  // APB decode
  wire       acc;
  wire       wr_go;
  wire       rd_go;
  wire [4:0] idx;
  wire       mapped;
  reg  [31:0] rd_mux;

  assign idx    = paddr[6:2];
  assign acc    = psel & penable & pready_r;
  assign wr_go  = acc & pwrite & mapped;
  assign rd_go  = acc & ~pwrite & mapped;
  assign mapped = (idx == `ADCS_IDX_CTRLA) | (idx == `ADCS_IDX_CTLC)
                | (idx == `ADCS_IDX_CTLD) | (idx == `ADCS_IDX_SAMPSET)
                | (idx == `ADCS_IDX_CHSEL) | (idx == `ADCS_IDX_COMMAND)
                | (idx == `ADCS_IDX_FLAGS) | (idx == `ADCS_IDX_OUT);

  assign busy        = (state_r != ST_IDLE);
  assign samp_cycles = `ADCS_SAMP_BASE + {3'h0, dly_r} + {2'h0, len_r};
  assign init_cycles = {init_r, 4'h0};
  assign done_tick   = tick & (state_r == ST_LAST);
  // Final cycle reopens the buffer path
  assign copy_en     = ~busy | (state_r == ST_LAST);
  // Keep the bit if input sits above trial; all-above gives all ones
  assign decided     = cmp_s_r ? trial_code_r : (trial_code_r & ~bit_r);

  adcs_presc u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (start_r & enable_r),
    .tick_r  (tick)
  );

  // Comparator crosses from the analog side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_m_r <= 1'b0;
      cmp_s_r <= 1'b0;
    end else begin
      cmp_m_r <= cmp_above;
      cmp_s_r <= cmp_m_r;
    end
  end

  // Read mux
  always @* begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `ADCS_IDX_CTRLA: begin
        rd_mux[`ADCS_CTRLA_ENABLE]  = enable_r;
        rd_mux[`ADCS_CTRLA_FREERUN] = freerun_r;
      end
      `ADCS_IDX_CTLC: begin
        rd_mux[`ADCS_CTLC_CAP] = capsel_r;
        rd_mux[`ADCS_CTLC_REF_HI:`ADCS_CTLC_REF_LO] = ref_buf_r;
      end
      `ADCS_IDX_CTLD: begin
        rd_mux[`ADCS_CTLD_INIT_HI:`ADCS_CTLD_INIT_LO] = init_r;
        rd_mux[`ADCS_CTLD_DLY_HI:`ADCS_CTLD_DLY_LO]   = dly_r;
      end
      `ADCS_IDX_SAMPSET: begin
        rd_mux[4:0] = len_r;
      end
      `ADCS_IDX_CHSEL: begin
        rd_mux[4:0] = chan_buf_r;
      end
      `ADCS_IDX_COMMAND: begin
        rd_mux[`ADCS_CMD_START] = start_r;
      end
      `ADCS_IDX_FLAGS: begin
        rd_mux[`ADCS_FLAG_RDY] = rdy_flag_r;
      end
      `ADCS_IDX_OUT: begin
        rd_mux[9:0] = res_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // APB handshake: one wait state, data and error registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel & penable & ~pready_r) begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~mapped;
    end else begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // Configuration fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r   <= 1'b0;
      freerun_r  <= 1'b0;
      capsel_r   <= 1'b0;
      ref_buf_r  <= `ADCS_RST_REF;
      init_r     <= `ADCS_RST_INIT;
      dly_r      <= `ADCS_RST_DLY;
      len_r      <= `ADCS_RST_LEN;
      chan_buf_r <= `ADCS_RST_CHAN;
    end else if (wr_go) begin
      if (idx == `ADCS_IDX_CTRLA) begin
        enable_r  <= pwdata[`ADCS_CTRLA_ENABLE];
        freerun_r <= pwdata[`ADCS_CTRLA_FREERUN];
      end
      if (idx == `ADCS_IDX_CTLC) begin
        capsel_r  <= pwdata[`ADCS_CTLC_CAP];
        ref_buf_r <= pwdata[`ADCS_CTLC_REF_HI:`ADCS_CTLC_REF_LO];
      end
      if (idx == `ADCS_IDX_CTLD) begin
        init_r <= pwdata[`ADCS_CTLD_INIT_HI:`ADCS_CTLD_INIT_LO];
        dly_r  <= pwdata[`ADCS_CTLD_DLY_HI:`ADCS_CTLD_DLY_LO];
      end
      if (idx == `ADCS_IDX_SAMPSET) begin
        len_r <= pwdata[4:0];
      end
      if (idx == `ADCS_IDX_CHSEL) begin
        chan_buf_r <= pwdata[4:0];
      end
    end
  end

  // Start bit: set by software, cleared by hardware
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
    end else if (!enable_r) begin
      start_r <= 1'b0;
    end else if (wr_go & (idx == `ADCS_IDX_COMMAND) & pwdata[`ADCS_CMD_START]) begin
      start_r <= 1'b1;
    end else if (done_tick & ~freerun_r) begin
      start_r <= 1'b0;
    end
  end

  // Ready flag; a completion in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_flag_r <= 1'b0;
    end else if (done_tick) begin
      rdy_flag_r <= 1'b1;
    end else if (rd_go & (idx == `ADCS_IDX_OUT)) begin
      rdy_flag_r <= 1'b0;
    end else if (wr_go & (idx == `ADCS_IDX_FLAGS) & pwdata[`ADCS_FLAG_RDY]) begin
      rdy_flag_r <= 1'b0;
    end
  end

  // Active copy of channel and reference
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_act_r <= `ADCS_RST_CHAN;
      ref_act_r  <= `ADCS_RST_REF;
    end else if (copy_en & (~busy | tick)) begin
      chan_act_r <= chan_buf_r;
      ref_act_r  <= ref_buf_r;
    end
  end

  // Sequencer, stepping once per converter clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ST_IDLE;
      cnt_r        <= 7'h00;
      bit_r        <= 10'h000;
      trial_code_r <= 10'h000;
      res_r        <= 10'h000;
      sample_r     <= 1'b0;
      first_r      <= 1'b1;
      chan_out_r   <= `ADCS_RST_CHAN;
      ref_out_r    <= `ADCS_RST_REF;
    end else if (!enable_r | !start_r) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 7'h00;
      sample_r <= 1'b0;
      first_r  <= ~enable_r | first_r;
      if (!busy) begin
        chan_out_r <= chan_act_r;
        ref_out_r  <= ref_act_r;
      end
    end else if (tick) begin
      case (state_r)
        ST_IDLE: begin
          // First edge after the start bit; wait only after enabling
          chan_out_r <= chan_act_r;
          ref_out_r  <= ref_act_r;
          cnt_r      <= 7'h00;
          if (first_r & (init_r != 3'h0)) begin
            state_r <= ST_INIT;
          end else begin
            state_r  <= ST_SAMP;
            sample_r <= 1'b1;
          end
        end
        ST_INIT: begin
          if (cnt_r == init_cycles - 7'h01) begin
            cnt_r    <= 7'h00;
            state_r  <= ST_SAMP;
            sample_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 7'h01;
          end
        end
        ST_SAMP: begin
          first_r <= 1'b0;
          if (cnt_r == samp_cycles - 7'h01) begin
            sample_r     <= 1'b0;
            state_r      <= ST_SAR;
            bit_r        <= `ADCS_SAR_TOP;
            trial_code_r <= `ADCS_SAR_TOP;
          end
          cnt_r <= cnt_r + 7'h01;
        end
        ST_SAR: begin
          // One bit decided per cycle, ten in all
          trial_code_r <= decided | {1'b0, bit_r[9:1]};
          bit_r        <= {1'b0, bit_r[9:1]};
          if (bit_r[0]) begin
            state_r <= ST_LAST;
          end
          cnt_r <= cnt_r + 7'h01;
        end
        ST_LAST: begin
          res_r <= trial_code_r;
          cnt_r <= 7'h00;
          if (freerun_r) begin
            // Next run starts now on the old active copy
            state_r    <= ST_SAMP;
            sample_r   <= 1'b1;
            chan_out_r <= chan_act_r;
            ref_out_r  <= ref_act_r;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Analog steering from the active copy and capacitor select, plus the ready pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_internal_r   <= 1'b0;
      temp_sensor_en_r <= 1'b0;
      samp_cap_r       <= 1'b0;
      ready_pulse_r    <= 1'b0;
    end else begin
      ref_internal_r   <= (ref_act_r == `ADCS_REF_INTERNAL);
      temp_sensor_en_r <= enable_r & (chan_act_r == `ADCS_CHAN_TEMP);
      samp_cap_r       <= capsel_r;
      ready_pulse_r    <= done_tick;
    end
  end

endmodule

// ---- sim/adcs_top_props.sv ----
`timescale 1ns/1ps
module adcs_top_props (
  // System
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [6:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_r,
  input wire        pready_r,
  input wire        pslverr_r,
  // Analog side
  input wire        cmp_above,
  input wire        sample_r,
  input wire [9:0]  trial_code_r,
  input wire [4:0]  chan_out_r,
  input wire [1:0]  ref_out_r,
  input wire        ref_internal_r,
  input wire        temp_sensor_en_r,
  input wire        samp_cap_r,
  input wire        ready_pulse_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PRDY_PULSE: assert property (pready_r |=> !pready_r)
    else $error("pready held");
  AST_APB_WAIT: assert property ((psel && !penable) ##1 (psel && penable) |->
    !pready_r ##1 pready_r) else $error("pready timing");
  AST_ERR_RDY: assert property (pslverr_r |-> pready_r)
    else $error("pslverr without pready");
  AST_PRD_ZERO: assert property (!pready_r |-> prdata_r == 32'h0)
    else $error("prdata outside answer");
  AST_SAMP_MIN: assert property ($rose(sample_r) |-> sample_r[*8])
    else $error("sampling too short");
  AST_CONV_LEN: assert property ($fell(sample_r) |-> ##[36:52] ready_pulse_r)
    else $error("conversion length");
  AST_SEL_FROZEN: assert property (sample_r && $past(sample_r) |->
    $stable(chan_out_r) && $stable(ref_out_r)) else $error("selection moved");
  AST_RDY_PULSE: assert property (ready_pulse_r |=> !ready_pulse_r)
    else $error("ready pulse held");
endmodule
bind adcs_top adcs_top_props i_props (.*);

// ---- sim/adcs_top_tb_top.sv ----
`timescale 1ns/1ps
`include "adcs_defines.vh"
module adcs_top_tb_top;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg         cmp_above;
  reg  [6:0]  paddr;
  reg  [31:0] pwdata;
  reg  [31:0] q;
  reg         e;
  reg  [10:0] vin;
  wire [31:0] prdata_r;
  wire        pready_r;
  wire        pslverr_r;
  wire        sample_r;
  wire [9:0]  trial_code_r;
  wire [4:0]  chan_out_r;
  wire [1:0]  ref_out_r;
  wire        ref_internal_r;
  wire        temp_sensor_en_r;
  wire        samp_cap_r;
  wire        ready_pulse_r;
  integer     err_count;
  integer     tests_run;
  integer     n;
  integer     i;
  adcs_top i_dut (.*);
  always #50 pclk = ~pclk;
  // Ideal input: keep a trial bit while the code does not exceed vin
  always @(posedge pclk) cmp_above <= ({1'h0, trial_code_r} <= vin);
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input w, input [4:0] ix, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      // Sample answer at the rising edge itself, before this edge's updates
      @(posedge pclk);
      while (pready_r !== 1'h1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      q = prdata_r;
      e = pslverr_r;
      psel <= 1'h0;
      penable <= 1'h0;
      chk("apb answer", n < 50, 1);
    end
  endtask
  // Counts cycles up to the next ready pulse
  task wp;
    begin
      n = 0;
      @(negedge pclk);
      while (ready_pulse_r !== 1'h1 && n < 2000) begin
        n = n + 1;
        @(negedge pclk);
      end
      chk("ready pulse seen", n < 2000, 1);
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        apb(1'h0, i, 32'h0);
        chk("reset read", q, 32'h0);
        chk("slverr", e, (i == 1 || i == 4 || i == 7 || i == 9 || i == 10));
      end
      chk("sample idle", sample_r, 1'h0);
      $display("t_reset done");
    end
  endtask
  task t_sel;
    begin
      apb(1'h1, `ADCS_IDX_CTRLA, 32'h1);
      apb(1'h1, `ADCS_IDX_CHSEL, 32'h1E);
      apb(1'h1, `ADCS_IDX_CTLC, 32'h40);
      apb(1'h0, `ADCS_IDX_CHSEL, 32'h0);
      chk("chan buffer", q, 32'h1E);
      chk("active chan", chan_out_r, `ADCS_CHAN_TEMP);
      chk("temp sensor", temp_sensor_en_r, 1'h1);
      chk("ref internal", ref_internal_r, 1'h1);
      chk("sampling_capacitor_select", samp_cap_r, 1'h1);
      for (i = 2; i > 0; i = i - 1) begin
        apb(1'h1, `ADCS_IDX_CTLC, i << 4);
        // Buffer, active copy, then outputs: three edges
        repeat (3) @(negedge pclk);
        chk("ref code", ref_out_r, i);
        chk("ref not internal", ref_internal_r, 1'h0);
      end
      apb(1'h1, `ADCS_IDX_CHSEL, 32'h3);
      $display("t_sel done");
    end
  endtask
  task t_single;
    begin
      apb(1'h1, `ADCS_IDX_CTLD, 32'h1);
      apb(1'h1, `ADCS_IDX_SAMPSET, 32'h2);
      for (i = 0; i < 2; i = i + 1) begin
        vin = i ? 11'h7FF : 11'h155;
        apb(1'h1, `ADCS_IDX_COMMAND, 32'h1);
        n = 0;
        @(negedge pclk);
        while (sample_r !== 1'h1 && n < 100) begin
          n = n + 1;
          @(negedge pclk);
        end
        n = 0;
        while (sample_r === 1'h1 && n < 100) begin
          n = n + 1;
          @(negedge pclk);
        end
        chk("sample length", n, 4 * (2 + 1 + 2));
        apb(1'h0, `ADCS_IDX_COMMAND, 32'h0);
        chk("start busy", q, 32'h1);
        wp;
        apb(1'h0, `ADCS_IDX_COMMAND, 32'h0);
        chk("start cleared", q, 32'h0);
        apb(1'h0, `ADCS_IDX_FLAGS, 32'h0);
        chk("ready set", q, 32'h1);
        if (i) begin
          apb(1'h1, `ADCS_IDX_FLAGS, 32'h1);
          apb(1'h0, `ADCS_IDX_FLAGS, 32'h0);
          chk("w1c clear", q, 32'h0);
        end
        apb(1'h0, `ADCS_IDX_OUT, 32'h0);
        chk("result", q, i ? {22'h0, `ADCS_OUT_MAX} : 32'h155);
        apb(1'h0, `ADCS_IDX_FLAGS, 32'h0);
        chk("read clear", q, 32'h0);
      end
      $display("t_single done");
    end
  endtask
  task t_free;
    begin
      vin = 11'h0AA;
      apb(1'h1, `ADCS_IDX_CTRLA, 32'h3);
      apb(1'h1, `ADCS_IDX_COMMAND, 32'h1);
      wp;
      apb(1'h1, `ADCS_IDX_CHSEL, 32'h5);
      chk("chan frozen", chan_out_r, 5'h03);
      wp;
      wp;
      chk("free period", n, 4 * (13 + 1 + 2) - 1);
      chk("new chan later", chan_out_r, 5'h05);
      apb(1'h1, `ADCS_IDX_CTRLA, 32'h1);
      wp;
      $display("t_free done");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 7'h00;
    pwdata = 32'h0;
    cmp_above = 1'h0;
    vin = 11'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_sel;
    t_single;
    t_free;
    results;
  end
endmodule
